// >>> dual_adc_convert_read_control.sv
`timescale 1ns/1ps
module dual_adc_convert_read_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic convert_start_n,
  input wire logic pair_select,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic unipolar_strap,
  input wire logic [adc_ctrl_pkg::data_w-1:0] pair_a_input_1,
  input wire logic [adc_ctrl_pkg::data_w-1:0] pair_a_input_2,
  input wire logic [adc_ctrl_pkg::data_w-1:0] pair_b_input_1,
  input wire logic [adc_ctrl_pkg::data_w-1:0] pair_b_input_2,
  output logic busy_ff,
  output logic hold_ff,
  output logic [adc_ctrl_pkg::data_w-1:0] data_out_ff,
  output logic data_oe_ff
);
  conv_if cv ();

  logic start_prev_ff;
  logic rd_prev_ff;
  logic strap_taken_ff;
  logic unipolar_ff;
  logic pair_ff;
  logic second_ff;
  logic [adc_ctrl_pkg::data_w-1:0] held1_ff;
  logic [adc_ctrl_pkg::data_w-1:0] held2_ff;
  logic [adc_ctrl_pkg::data_w-1:0] result1_ff;
  logic [adc_ctrl_pkg::data_w-1:0] result2_ff;
  logic start_edge;
  logic read_active;
  logic rd_rise;

  assign start_edge = start_prev_ff & ~convert_start_n & ~busy_ff;
  assign read_active = ~cs_n & ~rd_n;
  assign rd_rise = ~cs_n & ~rd_prev_ff & rd_n;
  assign cv.start = start_edge;

  conv_timer u_timer (
    .clk(clk),
    .rst(rst),
    .cv(cv)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
    end else begin
      start_prev_ff <= convert_start_n;
      rd_prev_ff <= rd_n;
    end
  end

  // Coding strap caught once after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_taken_ff <= 1'b0;
      unipolar_ff <= 1'b0;
    end else if (!strap_taken_ff) begin
      strap_taken_ff <= 1'b1;
      unipolar_ff <= unipolar_strap;
    end
  end

  // Sample both inputs of the chosen pair at the same edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pair_ff <= 1'b0;
      held1_ff <= adc_ctrl_pkg::data_zero;
      held2_ff <= adc_ctrl_pkg::data_zero;
    end else if (start_edge) begin
      pair_ff <= pair_select;
      held1_ff <= pair_select ? pair_b_input_1 : pair_a_input_1;
      held2_ff <= pair_select ? pair_b_input_2 : pair_a_input_2;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else if (start_edge) begin
      busy_ff <= 1'b1;
      hold_ff <= 1'b1;
    end else if (cv.done) begin
      busy_ff <= 1'b0;
      hold_ff <= 1'b0;
    end
  end

  // Offset-binary samples; flipping the MSB gives two's complement
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result1_ff <= adc_ctrl_pkg::data_zero;
      result2_ff <= adc_ctrl_pkg::data_zero;
    end else if (cv.done) begin
      if (unipolar_ff) begin
        result1_ff <= held1_ff;
        result2_ff <= held2_ff;
      end else begin
        result1_ff <= held1_ff ^ adc_ctrl_pkg::sign_flip;
        result2_ff <= held2_ff ^ adc_ctrl_pkg::sign_flip;
      end
    end
  end

  // Read order: advance on each strobe release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      second_ff <= 1'b0;
    end else if (start_edge) begin
      second_ff <= 1'b0;
    end else if (rd_rise) begin
      second_ff <= ~second_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_oe_ff <= 1'b0;
      data_out_ff <= adc_ctrl_pkg::data_zero;
    end else begin
      data_oe_ff <= read_active;
      if (read_active) begin
        data_out_ff <= second_ff ? result2_ff : result1_ff;
      end
    end
  end
endmodule // dual_adc_convert_read_control

// >>> adc_ctrl_pkg.sv
// Operation
// - Start falling edge holds both inputs, starts conversion
// - Results in output register within 5.2 us
// - Busy falls when both results are readable
// - First strobe gives input 1, second input 2
// - Starts no closer than 5.7 us apart
// - Bipolar results coded in two's complement
// - Unipolar results coded in straight binary
// - Just below zero gives all ones, zero gives zeros
// - Largest positive is zero then all ones
// - Most negative is one then all zeros
// - Start edge raises busy until conversion ends
// - Hold stages return to tracking at conversion end
// - Pair chosen by select level before start
package adc_ctrl_pkg;
  localparam int unsigned data_w = 14;
  localparam int unsigned clk_mhz = 200;
  localparam int unsigned conv_time_ns = 5200;
  localparam int unsigned conv_cycles = conv_time_ns * clk_mhz / 1000;
  localparam int unsigned cnt_w = $clog2(conv_cycles + 1);
  localparam int unsigned msb = data_w - 1;
  // Start edge is seen up to a cycle late and busy falls two cycles after
  // the last count, so the count stops three short of the full time
  localparam logic [cnt_w-1:0] cnt_last = cnt_w'(conv_cycles - 3);
  localparam logic [cnt_w-1:0] cnt_zero = '0;
  localparam logic [data_w-1:0] data_zero = '0;
  localparam logic [data_w-1:0] sign_flip = data_w'(1) << msb;
endpackage

// >>> conv_if.sv
`timescale 1ns/1ps
interface conv_if;
  logic start;
  logic done;
  modport ctrl (output start, input done);
  modport timer (input start, output done);
endinterface

// >>> conv_timer.sv
`timescale 1ns/1ps
module conv_timer (
  input wire logic clk,
  input wire logic rst,
  conv_if.timer cv
);
  logic [adc_ctrl_pkg::cnt_w-1:0] cnt_ff;
  logic run_ff;
  logic done_ff;

  assign cv.done = done_ff;

  // Fixed conversion length counted in cycles of the system clock clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= adc_ctrl_pkg::cnt_zero;
      run_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (cv.start) begin
        cnt_ff <= adc_ctrl_pkg::cnt_zero;
        run_ff <= 1'b1;
      end else if (run_ff) begin
        if (cnt_ff == adc_ctrl_pkg::cnt_last) begin
          run_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end
endmodule // conv_timer

// >>> adc_props.sv
`timescale 1ns/1ps
module adc_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic busy_ff,
  input wire logic hold_ff,
  input wire logic data_oe_ff,
  input wire logic [13:0] data_out_ff
);
  // Busy cycles allowed: full conversion time less the edge sampling cycle
  localparam int conv_max = adc_ctrl_pkg::conv_cycles - 1;
  int cnt_ff;
  // Counts sampled busy cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_ff <= 0;
    else cnt_ff <= busy_ff ? cnt_ff + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence go_s;
    $fell(convert_start_n) && !busy_ff;
  endsequence
  a_start_busy: assert property (go_s |=> busy_ff)
    else $error("no busy");
  a_conv_end: assert property ($fell(busy_ff) |-> cnt_ff == conv_max)
    else $error("conv time");
  a_conv_max: assert property (busy_ff |-> cnt_ff < conv_max)
    else $error("conv long");
  a_hold_track: assert property (hold_ff == busy_ff)
    else $error("hold");
  a_oe_on: assert property (!cs_n && !rd_n |=> data_oe_ff)
    else $error("oe off");
  a_oe_off: assert property (cs_n || rd_n |=> !data_oe_ff)
    else $error("oe on");
  a_data_quiet: assert property (cs_n || rd_n |=> $stable(data_out_ff))
    else $error("data moved");
  a_idle_stay: assert property (!busy_ff && convert_start_n |=> !busy_ff)
    else $error("busy rose");
  c_start: cover property (go_s);
  c_done: cover property ($fell(busy_ff));
  c_read: cover property (data_oe_ff && !busy_ff);
endmodule // adc_props
bind dual_adc_convert_read_control adc_props u_props (.clk, .rst,
  .convert_start_n, .cs_n, .rd_n, .busy_ff, .hold_ff, .data_oe_ff,
  .data_out_ff);

// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic [13:0] data_out_ff,
  output logic convert_start_n = 1'b1,
  output logic pair_select = 1'b0,
  output logic cs_n = 1'b1,
  output logic rd_n = 1'b1
);
  logic [13:0] q [$];
  task conv(input logic s);
    pair_select <= s;
    repeat (100) @(posedge clk);
    convert_start_n <= 1'b0;
    @(posedge clk);
    convert_start_n <= 1'b1;
  endtask
  task rd(input int n);
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (n) begin
      rd_n <= 1'b0;
      @(posedge clk);
      #1 q.push_back(data_out_ff);
      @(posedge clk);
      rd_n <= 1'b1;
      @(posedge clk);
    end
    cs_n <= 1'b1;
  endtask
endmodule // host_model

// >>> dual_adc_convert_read_control_tb.sv
`timescale 1ns/1ps
module dual_adc_convert_read_control_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] in_v [4] = '{14'h1fff, 14'h2000, 14'h3fff, 14'h0000};
  logic [13:0] e [2];
  logic [31:0] lf = 32'hb3db;
  logic uni = 1'b0;
  logic [13:0] flip;
  wire logic hold;
  int n_fail = 0;
  int n_tests = 0;
  wire logic [13:0] data_out_ff;
  wire logic busy_ff, convert_start_n, pair_select, cs_n, rd_n;
  always #2.5 clk = ~clk;
  dual_adc_convert_read_control DUT (.clk, .rst, .convert_start_n,
    .pair_select, .cs_n, .rd_n, .unipolar_strap(uni), .busy_ff,
    .pair_a_input_1(in_v[0]), .pair_a_input_2(in_v[1]),
    .pair_b_input_1(in_v[2]), .pair_b_input_2(in_v[3]),
    .hold_ff(hold), .data_out_ff, .data_oe_ff());
  host_model h (.clk, .data_out_ff, .convert_start_n, .pair_select,
    .cs_n, .rd_n);
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [13:0] s, input logic [13:0] x);
    n_tests++;
    if (s !== x) begin
      n_fail++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task complete_run;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task conv(input logic s, input bit rnd);
    int i;
    flip = uni ? 14'h0000 : adc_ctrl_pkg::sign_flip;
    e[0] = in_v[{s, 1'b0}] ^ flip;
    e[1] = in_v[{s, 1'b1}] ^ flip;
    h.conv(s);
    @(posedge clk);
    // Select may move once start is back high; the held pair must not
    h.pair_select <= ~s;
    // Inputs move during conversion; held samples must not
    for (i = 0; i < 4 && rnd; i++) begin
      in_v[i] <= lf[13:0];
      lf = nx(lf);
    end
    #1 chk(14'(busy_ff), 14'h1);
    chk(14'(hold), 14'h1);
    for (i = 0; i < 1100 && busy_ff === 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(14'(i), 14'(adc_ctrl_pkg::conv_cycles - 2));
    chk(14'(hold), 14'h0);
    if (i == 1100) complete_run;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      if (k == 6) begin
        // Second reset: straight binary coding is caught at release
        rst <= 1'b1;
        uni <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
      end
      conv(k[0], k > 1);
      h.rd(k == 3 ? 3 : k == 4 ? 1 : 2);
      for (int i = 0; h.q.size() > 0; i++) chk(h.q.pop_front(), e[i % 2]);
      $display("test %0d done", k);
    end
    complete_run;
  end
endmodule // dual_adc_convert_read_control_tb
